// [core/anr_pkg.sv]
package anr_pkg;

  // Register byte offsets on the APB.
  localparam logic [7:0] ANR_CTRL_OFS    = 8'h00;
  localparam logic [7:0] ANR_ADV_OFS     = 8'h04;
  localparam logic [7:0] ANR_PARTNER_OFS = 8'h08;
  localparam logic [7:0] ANR_STATUS_OFS  = 8'h0C;

  // Control register fields.
  localparam int ANR_CTRL_AN_EN_BIT = 0;
  localparam logic ANR_CTRL_AN_EN_RST = 1'b1;

  // Advertisement and partner register fields.
  localparam int ANR_ADV_HL_ABILITY_BIT = 0;
  localparam int ANR_ADV_HL_REQUEST_BIT = 1;
  localparam int ANR_ADV_ROLE_FORCED_BIT = 2;
  localparam int ANR_ADV_ROLE_MASTER_BIT = 3;
  localparam logic [3:0] ANR_ADV_RST = 4'h0;

  // Status register fields.
  localparam int ANR_STAT_DONE_BIT    = 0;
  localparam int ANR_STAT_RESULT_LSB  = 1;
  localparam int ANR_STAT_CAPABLE_BIT = 3;
  localparam int ANR_STAT_LVL_HI_BIT  = 4;
  localparam int ANR_STAT_MASTER_BIT  = 5;
  localparam int ANR_STAT_FAULT_BIT   = 6;
  localparam int ANR_STAT_STRAP_BIT   = 7;

  // Cycles after reset release before the synchronised straps are latched.
  localparam logic [1:0] ANR_STRAP_WAIT = 2'd3;

  // LFSR seed for the random role step.
  localparam logic [15:0] ANR_LFSR_SEED = 16'hACE1;

  typedef struct packed {
    logic role_master;
    logic role_forced;
    logic hl_request;
    logic hl_ability;
  } anr_adv_t;

  typedef enum logic [1:0] {
    ANR_ROLE_SLAVE,
    ANR_ROLE_MASTER,
    ANR_ROLE_FAULT
  } anr_role_t;

endpackage : anr_pkg

// [core/anr_level_resolve.sv]
`timescale 1ns/1ns
module anr_level_resolve
  import anr_pkg::*;
(
  // Advertisements.
  input  wire anr_pkg::anr_adv_t local_adv_i,
  input  wire anr_pkg::anr_adv_t partner_adv_i,
  // Result.
  output logic                   level_high_o
);

  // High level needs both abilities and at least one request.
  always_comb begin
    level_high_o = local_adv_i.hl_ability && partner_adv_i.hl_ability &&
                   (local_adv_i.hl_request ||
                    partner_adv_i.hl_request);
  end

endmodule : anr_level_resolve

// [core/anr_role_resolve.sv]
`timescale 1ns/1ns
module anr_role_resolve
  import anr_pkg::*;
(
  // Advertisements and random draw.
  input  wire anr_pkg::anr_adv_t  local_adv_i,
  input  wire anr_pkg::anr_adv_t  partner_adv_i,
  input  wire logic               random_bit_i,
  // Result.
  output anr_pkg::anr_role_t      role_o
);

  logic lf;
  logic pf;
  logic same;

  always_comb begin
    lf   = local_adv_i.role_forced;
    pf   = partner_adv_i.role_forced;
    same = local_adv_i.role_master == partner_adv_i.role_master;
    if (!same) begin
      role_o = local_adv_i.role_master ? ANR_ROLE_MASTER
                                       : ANR_ROLE_SLAVE;
    end else if (lf && pf) begin
      role_o = ANR_ROLE_FAULT;
    end else if (lf) begin
      role_o = local_adv_i.role_master ? ANR_ROLE_MASTER
                                       : ANR_ROLE_SLAVE;
    end else if (pf) begin
      role_o = partner_adv_i.role_master ? ANR_ROLE_SLAVE
                                         : ANR_ROLE_MASTER;
    end else begin
      role_o = random_bit_i ? ANR_ROLE_MASTER : ANR_ROLE_SLAVE;
    end
  end

endmodule : anr_role_resolve

// [core/anr_top.sv]
// Behaviour
// - Autonegotiation is enabled after reset; software may turn it off.
// - Read-only capability bit; high level usable only when it reads 1.
// - Ability bit: 0 low level only, 1 both levels; needs capability.
// - Request bit: 0 asks low level, 1 asks high; needs capability.
// - Partner level ability and request captured; valid once done is set.
// - Low level when either side lacks ability or nobody requests high.
// - High level only when both able and at least one requests.
// - Role forced bit: 0 preference, 1 forced.
// - Role master bit: 0 slave, 1 master.
// - Partner role forced and master bits captured; valid once done.
// - Same preferred role on both sides is settled by a random draw.
// - One side forcing the shared role wins; other side takes opposite.
// - Both forcing the same role gives a fault, fails, no link.
// - Readable role result: slave, master or fault; valid once done.
// - Unstrapped role pin defaults the advertisement to prefer slave.
// - Done bit reads 1 only when negotiation finished and link is up.
// - Low-level-only strap locks out software enabling the high level.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module anr_top
  import anr_pkg::*;
(
  // Clock and reset.
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  // APB slave.
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // Strap and supply pins.
  input  wire logic               role_preference_strap_i,
  input  wire logic               low_level_only_strap_i,
  input  wire logic               transmit_supply_rail_ok_i,
  // Page exchange engine.
  input  wire logic               partner_page_valid_i,
  input  wire anr_pkg::anr_adv_t  partner_page_i,
  input  wire logic               exchange_done_i,
  input  wire logic               link_up_i,
  output anr_pkg::anr_adv_t       local_adv_o,
  output logic                    an_enable_o,
  // Applied operating mode.
  output logic                    tx_level_high_o,
  output logic                    role_master_o,
  output logic                    config_fault_o
);

  logic [1:0]  role_sync_reg;
  logic [1:0]  low_sync_reg;
  logic [1:0]  rail_sync_reg;
  logic [1:0]  strap_cnt_reg;
  logic        strap_done_reg;
  logic        low_only_reg;
  logic        an_enable_reg;
  anr_adv_t    adv_reg;
  anr_adv_t    adv_next;
  anr_adv_t    partner_reg;
  logic [15:0] lfsr_reg;
  logic        rand_reg;
  logic        level_high;
  anr_role_t   role_now;
  anr_role_t   result_reg;
  logic        done_reg;
  logic        done_next;
  logic        level_reg;
  logic        master_reg;
  logic        fault_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        wr_en;
  logic        capable;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ANR_CTRL_OFS) || (a == ANR_ADV_OFS) ||
                  (a == ANR_PARTNER_OFS) || (a == ANR_STATUS_OFS);
  endfunction : addr_mapped

  // Pins pass two flip-flops before any logic reads them.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      role_sync_reg <= 2'b00;
      low_sync_reg  <= 2'b00;
      rail_sync_reg <= 2'b00;
    end else begin
      role_sync_reg <= {role_sync_reg[0], role_preference_strap_i};
      low_sync_reg  <= {low_sync_reg[0], low_level_only_strap_i};
      rail_sync_reg <= {rail_sync_reg[0], transmit_supply_rail_ok_i};
    end
  end

  assign capable = rail_sync_reg[1] && !low_only_reg;

  // Straps are latched once, a few cycles after reset release.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt_reg  <= 2'd0;
      strap_done_reg <= 1'b0;
      low_only_reg   <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= 2'(strap_cnt_reg + 2'd1);
      if (strap_cnt_reg == ANR_STRAP_WAIT) begin
        strap_done_reg <= 1'b1;
        low_only_reg   <= low_sync_reg[1];
      end
    end
  end

  // APB handshake: no wait states, answer registered.
  assign wr_en = psel_i && penable_i && pready_reg && pwrite_i;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= psel_i && !penable_i;
      pslverr_reg <= psel_i && !penable_i && !addr_mapped(paddr_i);
      prdata_reg  <= 32'h0000_0000;
      if (psel_i && !penable_i && !pwrite_i) begin
        unique case (paddr_i)
          ANR_CTRL_OFS: begin
            prdata_reg[ANR_CTRL_AN_EN_BIT] <= an_enable_reg;
          end
          ANR_ADV_OFS: begin
            prdata_reg[3:0] <= adv_reg;
          end
          ANR_PARTNER_OFS: begin
            prdata_reg[3:0] <= partner_reg;
          end
          ANR_STATUS_OFS: begin
            prdata_reg[ANR_STAT_DONE_BIT]    <= done_reg;
            prdata_reg[ANR_STAT_RESULT_LSB +: 2] <= result_reg;
            prdata_reg[ANR_STAT_CAPABLE_BIT] <= capable;
            prdata_reg[ANR_STAT_LVL_HI_BIT]  <= level_reg;
            prdata_reg[ANR_STAT_MASTER_BIT]  <= master_reg;
            prdata_reg[ANR_STAT_FAULT_BIT]   <= fault_reg;
            prdata_reg[ANR_STAT_STRAP_BIT]   <= low_only_reg;
          end
          default: begin
            prdata_reg <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      an_enable_reg <= ANR_CTRL_AN_EN_RST;
    end else if (wr_en && paddr_i == ANR_CTRL_OFS) begin
      an_enable_reg <= pwdata_i[ANR_CTRL_AN_EN_BIT];
    end
  end

  // High-level bits are forced to zero whenever the part is not capable.
  always_comb begin
    adv_next = adv_reg;
    if (wr_en && paddr_i == ANR_ADV_OFS) begin
      adv_next.hl_ability  = pwdata_i[ANR_ADV_HL_ABILITY_BIT];
      adv_next.hl_request  = pwdata_i[ANR_ADV_HL_REQUEST_BIT];
      adv_next.role_forced = pwdata_i[ANR_ADV_ROLE_FORCED_BIT];
      adv_next.role_master = pwdata_i[ANR_ADV_ROLE_MASTER_BIT];
    end
    if (!capable) begin
      adv_next.hl_ability = 1'b0;
      adv_next.hl_request = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adv_reg <= ANR_ADV_RST;
    end else if (!strap_done_reg) begin
      if (strap_cnt_reg == ANR_STRAP_WAIT) begin
        adv_reg.role_master <= role_sync_reg[1];
        adv_reg.role_forced <= 1'b0;
        adv_reg.hl_ability  <= rail_sync_reg[1] && !low_sync_reg[1];
        adv_reg.hl_request  <= 1'b0;
      end
    end else begin
      adv_reg <= adv_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      partner_reg <= ANR_ADV_RST;
    end else if (partner_page_valid_i) begin
      partner_reg <= partner_page_i;
    end
  end

  // Free-running LFSR; the draw is frozen when a page arrives.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfsr_reg <= ANR_LFSR_SEED;
      rand_reg <= 1'b0;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0],
                   lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      if (partner_page_valid_i) begin
        rand_reg <= lfsr_reg[0];
      end
    end
  end

  anr_level_resolve u_level (
    .local_adv_i   (adv_reg),
    .partner_adv_i (partner_reg),
    .level_high_o  (level_high)
  );

  anr_role_resolve u_role (
    .local_adv_i   (adv_reg),
    .partner_adv_i (partner_reg),
    .random_bit_i  (rand_reg),
    .role_o        (role_now)
  );

  assign done_next = an_enable_reg && exchange_done_i && link_up_i &&
                     (role_now != ANR_ROLE_FAULT);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_reg <= ANR_ROLE_SLAVE;
      done_reg   <= 1'b0;
      fault_reg  <= 1'b0;
    end else begin
      result_reg <= role_now;
      done_reg   <= done_next;
      fault_reg  <= an_enable_reg && exchange_done_i &&
                    (role_now == ANR_ROLE_FAULT);
    end
  end

  // Applied mode changes only on completion and holds otherwise.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg  <= 1'b0;
      master_reg <= 1'b0;
    end else if (done_next && !done_reg) begin
      level_reg  <= level_high;
      master_reg <= role_now == ANR_ROLE_MASTER;
    end
  end

  assign prdata_o        = prdata_reg;
  assign pready_o        = pready_reg;
  assign pslverr_o       = pslverr_reg;
  assign local_adv_o     = adv_reg;
  assign an_enable_o     = an_enable_reg;
  assign tx_level_high_o = level_reg;
  assign role_master_o   = master_reg;
  assign config_fault_o  = fault_reg;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_hl_needs_cap: assert property (
    strap_done_reg && !capable |=> !adv_reg.hl_ability && !adv_reg.hl_request)
    else $error("high level advertised while not capable");

  a_level_low: assert property (
    done_next && !done_reg &&
    (!adv_reg.hl_ability || !partner_reg.hl_ability) |=> !level_reg)
    else $error("high level applied without both abilities");

  a_level_high: assert property (
    done_next && !done_reg && adv_reg.hl_ability && partner_reg.hl_ability &&
    (adv_reg.hl_request || partner_reg.hl_request) |=> level_reg)
    else $error("high level not applied");

  a_fault_both: assert property (
    adv_reg.role_forced && partner_reg.role_forced &&
    adv_reg.role_master == partner_reg.role_master && exchange_done_i &&
    an_enable_reg |=> fault_reg && !done_reg && result_reg == ANR_ROLE_FAULT)
    else $error("missed configuration fault");

  a_forced_wins: assert property (
    adv_reg.role_forced && !partner_reg.role_forced &&
    adv_reg.role_master == partner_reg.role_master |=>
    result_reg == ($past(adv_reg.role_master) ? ANR_ROLE_MASTER
                                              : ANR_ROLE_SLAVE))
    else $error("forced role not granted");

  a_differ_own: assert property (
    adv_reg.role_master != partner_reg.role_master |=>
    result_reg == ($past(adv_reg.role_master) ? ANR_ROLE_MASTER
                                              : ANR_ROLE_SLAVE))
    else $error("differing roles not granted");

  a_hold_applied: assert property (
    !(done_next && !done_reg) |=> $stable(level_reg) && $stable(master_reg))
    else $error("applied mode changed outside completion");

  a_done_link: assert property (
    done_reg |-> $past(link_up_i) && $past(exchange_done_i))
    else $error("done set without link up");

  a_an_reset: assert property (
    $rose(rst_n_i) |-> an_enable_reg)
    else $error("autonegotiation off after reset");

  a_strap_slave: assert property (
    !strap_done_reg && strap_cnt_reg == ANR_STRAP_WAIT && !role_sync_reg[1]
    |=> !adv_reg.role_master && !adv_reg.role_forced)
    else $error("strap default not prefer slave");

  c_fault: cover property (fault_reg);
  c_high_level: cover property (done_reg && level_reg);
  c_random_role: cover property (
    !adv_reg.role_forced && !partner_reg.role_forced &&
    adv_reg.role_master == partner_reg.role_master && done_reg);

endmodule : anr_top

// [sim/anr_partner_model.sv]
`timescale 1ns/1ns
module anr_partner_model
  import anr_pkg::*;
(
  // Clock.
  input  wire logic               clk_i,
  // Page exchange towards the block.
  output logic                    page_valid_o,
  output anr_pkg::anr_adv_t       page_o,
  output logic                    exchange_done_o,
  output logic                    link_up_o
);

  initial begin
    page_valid_o    = 1'b0;
    page_o          = '0;
    exchange_done_o = 1'b0;
    link_up_o       = 1'b0;
  end

  // Drops the link so that the next result gets a fresh completion edge.
  task automatic restart(input int gap);
    @(posedge clk_i);
    exchange_done_o <= 1'b0;
    link_up_o       <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask : restart

  // The page lines carry the inverse afterwards so stale data is visible.
  task automatic send_page(input anr_adv_t pg);
    @(posedge clk_i);
    page_valid_o <= 1'b1;
    page_o       <= pg;
    @(posedge clk_i);
    page_valid_o <= 1'b0;
    page_o       <= anr_adv_t'(~pg);
  endtask : send_page

  task automatic complete(input logic up, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    exchange_done_o <= 1'b1;
    link_up_o       <= up;
  endtask : complete

endmodule : anr_partner_model

// [sim/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  import anr_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        strap_role;
  logic        strap_low;
  logic        rail_ok;
  logic        pg_valid;
  anr_adv_t    pg;
  logic        xdone;
  logic        link_up;
  anr_adv_t    loc_adv;
  logic        an_en;
  logic        lvl_hi;
  logic        role_m;
  logic        fault;
  logic [31:0] rdat;
  logic        rerr;
  logic        prev_lvl;
  logic        exp_m;
  logic [3:0]  v;
  int          bad_count;
  int          samples_checked;

  anr_top u_anr_top (
    .core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .role_preference_strap_i(strap_role),
    .low_level_only_strap_i(strap_low),
    .transmit_supply_rail_ok_i(rail_ok),
    .partner_page_valid_i(pg_valid), .partner_page_i(pg),
    .exchange_done_i(xdone), .link_up_i(link_up),
    .local_adv_o(loc_adv), .an_enable_o(an_en),
    .tx_level_high_o(lvl_hi), .role_master_o(role_m),
    .config_fault_o(fault)
  );

  anr_partner_model u_anr_partner_model (
    .clk_i(clk), .page_valid_o(pg_valid), .page_o(pg),
    .exchange_done_o(xdone), .link_up_o(link_up)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Pready and the answer are taken at the rising edge of the commit.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        close_out();
      end
      @(posedge clk);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdat, rerr);
    chk(rdat, exp);
  endtask : rd_chk

  task automatic do_reset(input logic role, input logic low);
    @(posedge clk);
    rst_n      <= 1'b0;
    strap_role <= role;
    strap_low  <= low;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : do_reset

  // Leaves the status word in rdat once the result is applied.
  task automatic nego(input anr_adv_t loc, input anr_adv_t prt,
                      input logic up);
    u_anr_partner_model.restart(1);
    wr(ANR_ADV_OFS, {28'h0, loc});
    u_anr_partner_model.send_page(prt);
    @(negedge clk);
    chk(32'(lvl_hi), 32'(prev_lvl));
    u_anr_partner_model.complete(up, 0);
    repeat (2) @(posedge clk);
    apb(1'b0, ANR_STATUS_OFS, 32'h0, rdat, rerr);
  endtask : nego

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    strap_role = 1'b0;
    strap_low = 1'b0;
    rail_ok = 1'b1;
    prev_lvl = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    do_reset(1'b0, 1'b0);
    chk(32'(an_en), 32'h1);
    rd_chk(ANR_CTRL_OFS, 32'h1);
    rd_chk(ANR_ADV_OFS, 32'h1);
    chk(32'(loc_adv), 32'h1);
    apb(1'b0, ANR_STATUS_OFS, 32'h0, rdat, rerr);
    chk(32'(rdat[7:3]), 32'h1);
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      exp_m = v[0] & v[2] & (v[1] | v[3]);
      nego({2'b00, v[1], v[0]}, {2'b10, v[3], v[2]}, 1'b1);
      chk(32'(loc_adv), 32'({2'b00, v[1], v[0]}));
      chk(32'(lvl_hi), 32'(exp_m));
      chk(32'({rdat[4], rdat[0]}), 32'({exp_m, 1'b1}));
      prev_lvl = exp_m;
      rd_chk(ANR_PARTNER_OFS, 32'({2'b10, v[3], v[2]}));
    end
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      nego({v[1], v[0], 2'b00}, {v[3], v[2], 2'b00}, 1'b1);
      chk(32'(loc_adv), 32'({v[1], v[0], 2'b00}));
      if (v[0] && v[2] && v[1] == v[3]) begin
        chk(32'(fault), 32'h1);
        chk(32'(rdat[2:0]), 32'({2'(ANR_ROLE_FAULT), 1'b0}));
      end else if (!v[0] && !v[2] && v[1] == v[3]) begin
        chk(32'(role_m), 32'(rdat[2:1] == 2'(ANR_ROLE_MASTER)));
        chk(32'({rdat[2], rdat[0], fault}), 32'h2);
        prev_lvl = 1'b0;
      end else begin
        exp_m = (v[1] != v[3] || v[0]) ? v[1] : !v[3];
        chk(32'(role_m), 32'(exp_m));
        chk(32'(rdat[2:0]), 32'({1'b0, exp_m, 1'b1}));
        chk(32'(fault), 32'h0);
        prev_lvl = 1'b0;
      end
    end
    nego(4'h0, 4'h8, 1'b0);
    chk(32'(rdat[0]), 32'h0);
    wr(ANR_CTRL_OFS, 32'h0);
    rd_chk(ANR_CTRL_OFS, 32'h0);
    chk(32'(an_en), 32'h0);
    nego(4'h0, 4'h8, 1'b1);
    chk(32'(rdat[0]), 32'h0);
    wr(ANR_CTRL_OFS, 32'h1);
    apb(1'b0, 8'h10, 32'h0, rdat, rerr);
    chk(32'(rerr), 32'h1);
    chk(rdat, 32'h0000_0000);
    u_anr_partner_model.restart(0);
    do_reset(1'b1, 1'b1);
    rd_chk(ANR_ADV_OFS, 32'h8);
    apb(1'b0, ANR_STATUS_OFS, 32'h0, rdat, rerr);
    chk(32'({rdat[7], rdat[3]}), 32'h2);
    wr(ANR_ADV_OFS, 32'hF);
    rd_chk(ANR_ADV_OFS, 32'hC);
    nego(4'hF, 4'h3, 1'b1);
    chk(32'({lvl_hi, role_m}), 32'h1);
    close_out();
  end

endmodule : tb_top
